// *** logic/stp_pkg.sv ***
// constants and types of the selector, table and privilege logic
package stp_pkg;
    // selector field layout
    localparam int SEL_LEVEL_LSB = 0;
    localparam int SEL_TABLE_BIT = 2;
    localparam int SEL_IDX_LSB = 3;
    localparam int SEL_IDX_W = 13;
    // descriptor and six-byte operand layout (byte 5 = access byte)
    localparam int DESC_W = 48;
    localparam int LIM_LSB = 0;
    localparam int BASE_LSB = 16;
    localparam int ACC_P_BIT = 47;
    localparam int ACC_LEVEL_LSB = 45;
    localparam int ACC_S_BIT = 44;
    localparam int ACC_TYPE_LSB = 40;
    // exception vectors
    localparam logic [7:0] EXC_NOT_PRESENT = 8'h0b;
    localparam logic [7:0] EXC_PROTECTION = 8'h0d;
    // system descriptor types
    localparam logic [3:0] TYPE_LDT = 4'h2;
    localparam logic [3:0] TYPE_TASK_GATE = 4'h5;
    localparam logic [3:0] TYPE_INT_GATE = 4'h6;
    localparam logic [3:0] TYPE_TRAP_GATE = 4'h7;
    // privilege levels
    localparam logic [1:0] LEVEL_MOST = 2'h0;
    localparam logic [1:0] LEVEL_LEAST = 2'h3;
    // reset values
    localparam logic [23:0] BASE_RST = 24'h000000;
    localparam logic [15:0] LIMIT_RST = 16'h0000;
    localparam logic [15:0] INTR_LIMIT_RST = 16'h03ff;
    localparam logic [47:0] DESC_RST = 48'h000000000000;
    // operations offered on the request port
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_LOAD_GLOBAL = 3'b001,
        OP_LOAD_LOCAL = 3'b010,
        OP_LOAD_INTR = 3'b011,
        OP_SEG_LOAD = 3'b100,
        OP_INTR_LOOKUP = 3'b101
    } op_e;
endpackage

// *** logic/effective_level_unit.sv ***
// effective level of a selector and its check against a descriptor level
`timescale 1ns/1ps
`default_nettype none
module effective_level_unit (
    input wire logic [1:0] current_level, // level of running code
    input wire logic [1:0] requested_level, // level carried by selector
    input wire logic [1:0] descriptor_level, // level of descriptor
    output logic [1:0] effective_level, // numeric max of both
    output logic level_ok // descriptor usable
);
    // numeric maximum, so requested level 0 adds nothing
    always_comb begin
        effective_level = (requested_level > current_level) ? requested_level : current_level;
        level_ok = (effective_level <= descriptor_level);
    end
endmodule
`default_nettype wire

// *** logic/descriptor_cache.sv ***
// hidden descriptor cache of the four segment registers
`timescale 1ns/1ps
`default_nettype none
module descriptor_cache (
    input wire logic ref_clk, // clock
    input wire logic rst, // async reset, high
    input wire logic wr_en, // write strobe
    input wire logic [1:0] wr_seg, // segment written
    input wire logic [47:0] wr_data, // descriptor written
    input wire logic [1:0] rd_seg, // segment read
    output logic [47:0] rd_data // registered read data
);
    import stp_pkg::*;
    typedef struct packed {
        logic [3:0][47:0] entry;
        logic [47:0] rd;
    } cache_s;
    cache_s cur_ff;
    cache_s nxt_ff;
    // write, and registered read of the entry as stored before this cycle's write
    always_comb begin
        nxt_ff = cur_ff;
        if (wr_en) begin
            nxt_ff.entry[wr_seg] = wr_data;
        end
        nxt_ff.rd = cur_ff.entry[rd_seg];
    end
    // state register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end
    assign rd_data = cur_ff.rd;
endmodule
`default_nettype wire

// *** logic/selector_table_privilege_check.sv ***
// selector decode, descriptor table registers and privilege checks
// Notes on behaviour
// - selector: level 1:0, table bit 2, index 15:3
// - thirteen-bit index, up to 8192 entries per table
// - each table has 24-bit base, 16-bit limit
// - entry beyond table limit raises exception 13
// - descriptor not present refuses the segment access
// - table loads execute only at current level 0
// - global load takes six-byte limit and base
// - local load fetches descriptor named by selector
// - interrupt table of 256, only gate types allowed
// - interrupt table loaded like global table, privileged
// - interrupt table indexed by vectors and exceptions
// - four levels, 0 the most privileged
// - current level is code selector low bits
// - current level changes only through gate transfer or task switch
// - task switch sets level from task's code
// - descriptor level bounds user, table descriptors exempt
// - effective level is max of requested, current
// - requested 0 free, requested 3 only level 3
// - segment load caches its descriptor for later use
// - gate not present raises exception 11
`timescale 1ns/1ps
`default_nettype none
module selector_table_privilege_check (
    input wire logic ref_clk, // clock, 100 MHz
    input wire logic rst, // async reset, high
    input wire logic op_valid, // request present
    output logic op_ready, // request can be taken
    input wire stp_pkg::op_e op_code, // requested operation
    input wire logic [15:0] op_selector, // selector operand
    input wire logic [47:0] op_operand, // six-byte operand
    input wire logic [1:0] op_seg, // segment register number
    input wire logic [7:0] op_vector, // interrupt vector
    output logic op_done, // pulse, operation completed
    output logic op_fault, // pulse, operation faulted
    output logic [7:0] fault_vector, // exception number
    output logic [47:0] result_desc, // last descriptor fetched
    output logic fetch_req, // descriptor read request
    output logic [23:0] fetch_addr, // descriptor address
    input wire logic fetch_ack, // descriptor read answered
    input wire logic [47:0] fetch_data, // descriptor read data
    input wire logic gate_transfer, // pulse, gate into new code
    input wire logic task_switch, // pulse, task entered
    input wire logic [15:0] new_cs_selector, // selector of new code
    output logic [1:0] current_level, // running level
    input wire logic [15:0] probe_selector, // selector to decode
    output logic [12:0] probe_index, // decoded entry index
    output logic table_select_bit, // decoded table choice
    output logic [1:0] requested_level, // decoded requested level
    output logic [1:0] effective_level, // decoded effective level
    output logic [23:0] global_base, // global table base
    output logic [15:0] global_limit, // global table limit
    output logic [23:0] local_base, // local table base
    output logic [15:0] local_limit, // local table limit
    output logic [23:0] intr_base, // interrupt table base
    output logic [15:0] intr_limit, // interrupt table limit
    input wire logic [1:0] cache_rd_seg, // cached segment to read
    output logic [47:0] cache_rd_data // cached descriptor
);
    import stp_pkg::*;

    // ********************************
    // state
    // ********************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_CHECK = 2'b10
    } state_e;

    typedef struct packed {
        state_e state;
        op_e op;
        logic [15:0] sel;
        logic [1:0] seg;
        logic [23:0] gdt_base;
        logic [15:0] gdt_lim;
        logic [23:0] ldt_base;
        logic [15:0] ldt_lim;
        logic [23:0] idt_base;
        logic [15:0] idt_lim;
        logic [1:0] cur_level;
        logic [23:0] fetch_addr;
        logic [47:0] desc;
        logic [47:0] result;
        logic done;
        logic fault;
        logic [7:0] fault_code;
        logic cache_we;
        logic [12:0] p_idx;
        logic p_tbl;
        logic [1:0] p_req;
        logic [1:0] p_eff;
    } core_s;

    core_s cur_ff;
    core_s nxt_ff;

    logic take;
    logic [12:0] op_idx;
    logic op_tbl;
    logic [12:0] vec_idx;
    logic chk_ok;
    logic [1:0] probe_eff;
    logic [3:0] d_type;
    logic d_present;
    logic d_system;

    // ********************************
    // helpers
    // ********************************
    // last byte of an entry must not pass the limit
    function automatic logic entry_in_limit(input logic [12:0] idx, input logic [15:0] lim);
        return ({idx, 3'b111} <= lim);
    endfunction

    // entry address is base plus eight times index
    function automatic logic [23:0] entry_addr(input logic [23:0] base, input logic [12:0] idx);
        return base + {8'h00, idx, 3'b000};
    endfunction

    // request decode
    assign take = op_valid && op_ready;
    assign op_idx = op_selector[SEL_IDX_LSB +: SEL_IDX_W];
    assign op_tbl = op_selector[SEL_TABLE_BIT];
    assign vec_idx = {5'h00, op_vector};
    assign d_type = cur_ff.desc[ACC_TYPE_LSB +: 4];
    assign d_present = cur_ff.desc[ACC_P_BIT];
    assign d_system = !cur_ff.desc[ACC_S_BIT];

    // privilege of the pending selector against fetched descriptor
    effective_level_unit u_check_level (
        .current_level(cur_ff.cur_level),
        .requested_level(cur_ff.sel[SEL_LEVEL_LSB +: 2]),
        .descriptor_level(cur_ff.desc[ACC_LEVEL_LSB +: 2]),
        .effective_level(),
        .level_ok(chk_ok)
    );

    // effective level of the probed selector
    effective_level_unit u_probe_level (
        .current_level(cur_ff.cur_level),
        .requested_level(probe_selector[SEL_LEVEL_LSB +: 2]),
        .descriptor_level(LEVEL_LEAST),
        .effective_level(probe_eff),
        .level_ok()
    );

    // ********************************
    // next state
    // ********************************
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.done = 1'b0;
        nxt_ff.fault = 1'b0;
        nxt_ff.cache_we = 1'b0;
        // probe decode, registered
        nxt_ff.p_idx = probe_selector[SEL_IDX_LSB +: SEL_IDX_W];
        nxt_ff.p_tbl = probe_selector[SEL_TABLE_BIT];
        nxt_ff.p_req = probe_selector[SEL_LEVEL_LSB +: 2];
        nxt_ff.p_eff = probe_eff;
        // level moves only on gate transfer or task switch
        if (gate_transfer || task_switch) begin
            nxt_ff.cur_level = new_cs_selector[SEL_LEVEL_LSB +: 2];
        end
        case (cur_ff.state)
            ST_IDLE: begin
                if (take) begin
                    nxt_ff.op = op_code;
                    nxt_ff.sel = op_selector;
                    nxt_ff.seg = op_seg;
                    case (op_code)
                        OP_LOAD_GLOBAL: begin
                            if (cur_ff.cur_level != LEVEL_MOST) begin
                                nxt_ff.fault = 1'b1;
                                nxt_ff.fault_code = EXC_PROTECTION;
                            end else begin
                                nxt_ff.gdt_lim = op_operand[LIM_LSB +: 16];
                                nxt_ff.gdt_base = op_operand[BASE_LSB +: 24];
                                nxt_ff.done = 1'b1;
                            end
                        end
                        OP_LOAD_INTR: begin
                            if (cur_ff.cur_level != LEVEL_MOST) begin
                                nxt_ff.fault = 1'b1;
                                nxt_ff.fault_code = EXC_PROTECTION;
                            end else begin
                                nxt_ff.idt_lim = op_operand[LIM_LSB +: 16];
                                nxt_ff.idt_base = op_operand[BASE_LSB +: 24];
                                nxt_ff.done = 1'b1;
                            end
                        end
                        OP_LOAD_LOCAL: begin
                            // table descriptor must sit in global table
                            if (cur_ff.cur_level != LEVEL_MOST || op_tbl
                                || !entry_in_limit(op_idx, cur_ff.gdt_lim)) begin
                                nxt_ff.fault = 1'b1;
                                nxt_ff.fault_code = EXC_PROTECTION;
                            end else begin
                                nxt_ff.fetch_addr = entry_addr(cur_ff.gdt_base, op_idx);
                                nxt_ff.state = ST_FETCH;
                            end
                        end
                        OP_SEG_LOAD: begin
                            if (op_tbl) begin
                                if (!entry_in_limit(op_idx, cur_ff.ldt_lim)) begin
                                    nxt_ff.fault = 1'b1;
                                    nxt_ff.fault_code = EXC_PROTECTION;
                                end else begin
                                    nxt_ff.fetch_addr = entry_addr(cur_ff.ldt_base, op_idx);
                                    nxt_ff.state = ST_FETCH;
                                end
                            end else begin
                                if (!entry_in_limit(op_idx, cur_ff.gdt_lim)) begin
                                    nxt_ff.fault = 1'b1;
                                    nxt_ff.fault_code = EXC_PROTECTION;
                                end else begin
                                    nxt_ff.fetch_addr = entry_addr(cur_ff.gdt_base, op_idx);
                                    nxt_ff.state = ST_FETCH;
                                end
                            end
                        end
                        OP_INTR_LOOKUP: begin
                            if (!entry_in_limit(vec_idx, cur_ff.idt_lim)) begin
                                nxt_ff.fault = 1'b1;
                                nxt_ff.fault_code = EXC_PROTECTION;
                            end else begin
                                nxt_ff.fetch_addr = entry_addr(cur_ff.idt_base, vec_idx);
                                nxt_ff.state = ST_FETCH;
                            end
                        end
                        default: begin
                            nxt_ff.done = 1'b1;
                        end
                    endcase
                end
            end
            ST_FETCH: begin
                if (fetch_ack) begin
                    nxt_ff.desc = fetch_data;
                    nxt_ff.state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                nxt_ff.state = ST_IDLE;
                nxt_ff.result = cur_ff.desc;
                case (cur_ff.op)
                    OP_LOAD_LOCAL: begin
                        if (!d_system || d_type != TYPE_LDT) begin
                            nxt_ff.fault = 1'b1;
                            nxt_ff.fault_code = EXC_PROTECTION;
                        end else if (!d_present) begin
                            nxt_ff.fault = 1'b1;
                            nxt_ff.fault_code = EXC_NOT_PRESENT;
                        end else begin
                            nxt_ff.ldt_lim = cur_ff.desc[LIM_LSB +: 16];
                            nxt_ff.ldt_base = cur_ff.desc[BASE_LSB +: 24];
                            nxt_ff.done = 1'b1;
                        end
                    end
                    OP_SEG_LOAD: begin
                        if (!d_present) begin
                            nxt_ff.fault = 1'b1;
                            nxt_ff.fault_code = EXC_NOT_PRESENT;
                        end else if (!(d_system && d_type == TYPE_LDT) && !chk_ok) begin
                            nxt_ff.fault = 1'b1;
                            nxt_ff.fault_code = EXC_PROTECTION;
                        end else begin
                            nxt_ff.cache_we = 1'b1;
                            nxt_ff.done = 1'b1;
                        end
                    end
                    OP_INTR_LOOKUP: begin
                        if (!d_system || (d_type != TYPE_TASK_GATE && d_type != TYPE_INT_GATE
                            && d_type != TYPE_TRAP_GATE)) begin
                            nxt_ff.fault = 1'b1;
                            nxt_ff.fault_code = EXC_PROTECTION;
                        end else if (!d_present) begin
                            nxt_ff.fault = 1'b1;
                            nxt_ff.fault_code = EXC_NOT_PRESENT;
                        end else begin
                            nxt_ff.done = 1'b1;
                        end
                    end
                    default: begin
                        nxt_ff.done = 1'b1;
                    end
                endcase
            end
            default: begin
                nxt_ff.state = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_ff <= '0;
            cur_ff.state <= ST_IDLE;
            cur_ff.op <= OP_NONE;
            cur_ff.gdt_base <= BASE_RST;
            cur_ff.gdt_lim <= LIMIT_RST;
            cur_ff.ldt_base <= BASE_RST;
            cur_ff.ldt_lim <= LIMIT_RST;
            cur_ff.idt_base <= BASE_RST;
            cur_ff.idt_lim <= INTR_LIMIT_RST;
            cur_ff.cur_level <= LEVEL_MOST;
            cur_ff.desc <= DESC_RST;
            cur_ff.result <= DESC_RST;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // hidden cache of segment descriptors
    descriptor_cache u_cache (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_en(cur_ff.cache_we),
        .wr_seg(cur_ff.seg),
        .wr_data(cur_ff.result),
        .rd_seg(cache_rd_seg),
        .rd_data(cache_rd_data)
    );

    // ********************************
    // outputs
    // ********************************
    assign op_ready = (cur_ff.state == ST_IDLE);
    assign fetch_req = (cur_ff.state == ST_FETCH);
    assign fetch_addr = cur_ff.fetch_addr;
    assign op_done = cur_ff.done;
    assign op_fault = cur_ff.fault;
    assign fault_vector = cur_ff.fault_code;
    assign result_desc = cur_ff.result;
    assign current_level = cur_ff.cur_level;
    assign probe_index = cur_ff.p_idx;
    assign table_select_bit = cur_ff.p_tbl;
    assign requested_level = cur_ff.p_req;
    assign effective_level = cur_ff.p_eff;
    assign global_base = cur_ff.gdt_base;
    assign global_limit = cur_ff.gdt_lim;
    assign local_base = cur_ff.ldt_base;
    assign local_limit = cur_ff.ldt_lim;
    assign intr_base = cur_ff.idt_base;
    assign intr_limit = cur_ff.idt_lim;

    // ********************************
    // checks
    // ********************************
    sequence s_take_global;
        take && op_code == OP_LOAD_GLOBAL;
    endsequence

    sequence s_fault13;
        op_fault && !op_done && fault_vector == EXC_PROTECTION;
    endsequence

    property p_global_priv;
        @(posedge ref_clk) disable iff (rst)
        s_take_global ##0 (current_level != LEVEL_MOST) |=> s_fault13 ##0 $stable(global_base);
    endproperty
    a_global_priv: assert property (p_global_priv) else $error("unprivileged global load");

    property p_global_load;
        @(posedge ref_clk) disable iff (rst)
        s_take_global ##0 (current_level == LEVEL_MOST)
        |=> op_done && global_base == $past(op_operand[39:16])
            && global_limit == $past(op_operand[15:0]);
    endproperty
    a_global_load: assert property (p_global_load) else $error("global load wrong");

    property p_intr_load;
        @(posedge ref_clk) disable iff (rst)
        take && op_code == OP_LOAD_INTR && current_level == LEVEL_MOST
        |=> intr_base == $past(op_operand[39:16]) && intr_limit == $past(op_operand[15:0]);
    endproperty
    a_intr_load: assert property (p_intr_load) else $error("interrupt load wrong");

    property p_limit;
        @(posedge ref_clk) disable iff (rst)
        take && op_code == OP_SEG_LOAD && !op_selector[2]
        && {op_selector[15:3], 3'b111} > global_limit |=> s_fault13 ##0 !fetch_req;
    endproperty
    a_limit: assert property (p_limit) else $error("limit not enforced");

    property p_decode;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> probe_index == $past(probe_selector[15:3])
            && table_select_bit == $past(probe_selector[2])
            && requested_level == $past(probe_selector[1:0]);
    endproperty
    a_decode: assert property (p_decode) else $error("selector decode wrong");

    property p_level_hold;
        @(posedge ref_clk) disable iff (rst)
        !gate_transfer && !task_switch |=> $stable(current_level);
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("level moved");

    property p_task_level;
        @(posedge ref_clk) disable iff (rst)
        task_switch |=> current_level == $past(new_cs_selector[1:0]);
    endproperty
    a_task_level: assert property (p_task_level) else $error("task level wrong");

    property p_effective;
        @(posedge ref_clk) disable iff (rst)
        !gate_transfer && !task_switch && probe_selector[1:0] == LEVEL_LEAST
        |=> effective_level == LEVEL_LEAST;
    endproperty
    a_effective: assert property (p_effective) else $error("effective level wrong");

    property p_not_present;
        @(posedge ref_clk) disable iff (rst)
        cur_ff.state == ST_CHECK && cur_ff.op == OP_SEG_LOAD && !d_present
        |=> op_fault && fault_vector == EXC_NOT_PRESENT && !cur_ff.cache_we;
    endproperty
    a_not_present: assert property (p_not_present) else $error("absent segment used");

    property p_gate_absent;
        @(posedge ref_clk) disable iff (rst)
        cur_ff.state == ST_CHECK && cur_ff.op == OP_INTR_LOOKUP && d_system
        && d_type == TYPE_INT_GATE && !d_present |=> op_fault && fault_vector == EXC_NOT_PRESENT;
    endproperty
    a_gate_absent: assert property (p_gate_absent) else $error("absent gate used");
endmodule
`default_nettype wire

// *** tb/tb_selector_table_privilege_check.sv ***
// bench for selector decode, table loads and privilege checks
`timescale 1ns/1ps
`default_nettype none
module tb_selector_table_privilege_check;
    import stp_pkg::*;
    logic ref_clk = 0, rst = 1, op_valid = 0, fetch_ack = 0, gate_transfer = 0, task_switch = 0;
    op_e op_code = OP_NONE;
    logic [15:0] op_selector = 0, new_cs_selector = 0, probe_selector = 0;
    logic [47:0] op_operand = 0, fetch_data = 0, desc = 0;
    logic [1:0] op_seg = 0, cache_rd_seg = 0, current_level, requested_level, effective_level;
    logic op_ready, op_done, op_fault, fetch_req, table_select_bit;
    logic [7:0] fault_vector, op_vector = 0;
    logic [47:0] result_desc, cache_rd_data;
    logic [23:0] fetch_addr, global_base, local_base, intr_base, exp_addr = 0;
    logic [15:0] global_limit, local_limit, intr_limit;
    logic [12:0] probe_index;
    int fails = 0, cmp_count = 0, cyc = 0;
    selector_table_privilege_check selector_table_privilege_check_i (.ref_clk(ref_clk),
        .rst(rst), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
        .op_selector(op_selector), .op_operand(op_operand), .op_seg(op_seg),
        .op_vector(op_vector), .op_done(op_done), .op_fault(op_fault),
        .fault_vector(fault_vector), .result_desc(result_desc), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
        .gate_transfer(gate_transfer), .task_switch(task_switch), .new_cs_selector(new_cs_selector),
        .current_level(current_level), .probe_selector(probe_selector),
        .probe_index(probe_index), .table_select_bit(table_select_bit),
        .requested_level(requested_level), .effective_level(effective_level),
        .global_base(global_base), .global_limit(global_limit), .local_base(local_base),
        .local_limit(local_limit), .intr_base(intr_base), .intr_limit(intr_limit),
        .cache_rd_seg(cache_rd_seg), .cache_rd_data(cache_rd_data));
    // clock and cycle ceiling
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            conclude();
        end
    end
    // descriptor memory answers each fetch after one cycle
    always @(negedge ref_clk) begin
        if (fetch_req === 1'b1 && !fetch_ack) chk("fetch_addr", 48'(exp_addr), 48'(fetch_addr));
        fetch_ack <= (fetch_req === 1'b1) && !fetch_ack;
        fetch_data <= desc;
    end
    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one request, then wait for its answer pulse
    task automatic op(input op_e c, input logic [15:0] s, input logic [47:0] d);
        int n;
        @(negedge ref_clk);
        while (op_ready !== 1'b1) @(negedge ref_clk);
        op_valid = 1;
        op_code = c;
        op_selector = s;
        op_operand = d;
        @(negedge ref_clk);
        op_valid = 0;
        n = 0;
        while (op_done !== 1'b1 && op_fault !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    task automatic probe(input logic [15:0] s);
        @(negedge ref_clk);
        probe_selector = s;
        @(negedge ref_clk);
    endtask
    task automatic conclude();
        $display("tests over, %0d compares, %0d mismatches", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(negedge ref_clk);
        rst = 0;
        chk("intr_limit", 48'h3ff, 48'(intr_limit));
        chk("current_level", 48'h0, 48'(current_level));
        probe(16'hffff);
        chk("probe_index", 48'h1fff, 48'(probe_index));
        chk("table_bit", 48'h1, 48'(table_select_bit));
        chk("requested", 48'h3, 48'(requested_level));
        chk("effective", 48'h3, 48'(effective_level));
        op(OP_LOAD_GLOBAL, 16'h0, 48'h00_001000_00ff);
        chk("global", 48'h1000_00ff, 48'({global_base, global_limit}));
        op(OP_LOAD_INTR, 16'h0, 48'h00_002000_07ff);
        chk("intr", 48'h2000_07ff, 48'({intr_base, intr_limit}));
        desc = 48'h82_004000_01ff;
        exp_addr = 24'h001010;
        op(OP_LOAD_LOCAL, 16'h0010, 48'h0);
        chk("local", 48'h4000_01ff, 48'({local_base, local_limit}));
        desc = 48'h06_000000_0000;
        exp_addr = 24'h002010;
        op_vector = 8'h02;
        op(OP_INTR_LOOKUP, 16'h0, 48'h0);
        chk("gate_fault", 48'h10b, 48'({op_fault, fault_vector}));
        $display("test table loads done");
        desc = 48'hf2_003000_0fff;
        exp_addr = 24'h001008;
        op_seg = 2'h1;
        cache_rd_seg = 2'h1;
        op(OP_SEG_LOAD, 16'h0008, 48'h0);
        chk("seg_done", 48'h1, 48'(op_done));
        chk("result_desc", desc, result_desc);
        repeat (3) @(negedge ref_clk);
        chk("cache", desc, cache_rd_data);
        op(OP_SEG_LOAD, 16'h0100, 48'h0);
        chk("limit_fault", 48'h10d, 48'({op_fault, fault_vector}));
        desc = 48'h72_003000_0fff;
        op(OP_SEG_LOAD, 16'h0008, 48'h0);
        chk("absent_fault", 48'h10b, 48'({op_fault, fault_vector}));
        $display("test segment loads done");
        @(negedge ref_clk);
        gate_transfer = 1;
        new_cs_selector = 16'h0003;
        @(negedge ref_clk);
        gate_transfer = 0;
        chk("current_level", 48'h3, 48'(current_level));
        probe(16'h0008);
        chk("effective", 48'h3, 48'(effective_level));
        op(OP_LOAD_GLOBAL, 16'h0, 48'h00_00aaaa_0055);
        chk("priv_fault", 48'h10d, 48'({op_fault, fault_vector}));
        chk("global", 48'h1000_00ff, 48'({global_base, global_limit}));
        desc = 48'h92_003000_0fff;
        op(OP_SEG_LOAD, 16'h0008, 48'h0);
        chk("level_fault", 48'h10d, 48'({op_fault, fault_vector}));
        @(negedge ref_clk);
        task_switch = 1;
        new_cs_selector = 16'h0001;
        @(negedge ref_clk);
        task_switch = 0;
        chk("task_level", 48'h1, 48'(current_level));
        $display("test privilege done");
        conclude();
    end
endmodule
`default_nettype wire
